// file: hw/pau_consts.svh
// constants of the process alarm unit: sizes, codes, timing counts
// assumes a 20 MHz system clock
`ifndef PAU_CONSTS_SVH
`define PAU_CONSTS_SVH
`define PAU_NUM_ALARMS 4
`define PAU_NUM_FUNCS 9
`define PAU_NUM_OUTS 5
`define PAU_VAL_W 16
`define PAU_SRC_W 14
`define PAU_FN_SENSOR_BREAK 0
`define PAU_FN_LOOP_BREAK 1
`define PAU_FN_LOAD_FAIL 2
`define PAU_FN_MANUAL 3
`define PAU_FN_OUT_RANGE 4
`define PAU_FN_REMOTE_SP_FAIL 5
`define PAU_FN_HEATER_FAIL 6
`define PAU_FN_RELAY_FAIL 7
`define PAU_FN_PROGRAM_END 8
`define PAU_SRC_FUNC_BASE 4
`define PAU_SRC_NEW_ALARM 13
`define PAU_CLK_HZ 20000000
`define PAU_CLEAR_HOLD_S 2
`define PAU_CLEAR_HOLD_CYC (`PAU_CLEAR_HOLD_S * `PAU_CLK_HZ)
`define PAU_LOOP_TIMEOUT_SAMPLES 16'h0040
`endif

// file: hw/pau_pkg.sv
// types of the process alarm unit
// used together with pau_consts.svh
`include "pau_consts.svh"
package pau_pkg;
   typedef enum logic [2:0] {
      PAU_FS_HIGH = 3'h0,
      PAU_FS_LOW = 3'h1,
      PAU_DEV_BAND = 3'h2,
      PAU_DEV_HIGH = 3'h3,
      PAU_DEV_LOW = 3'h4,
      PAU_CUR_HIGH = 3'h5,
      PAU_CUR_LOW = 3'h6
   } pau_type_t;
   typedef enum logic [1:0] {
      PAU_LATCH_OFF = 2'h0,
      PAU_LATCH_AUTO = 2'h1,
      PAU_LATCH_MANUAL = 2'h2
   } pau_latch_t;
   typedef struct packed {
      pau_type_t alarm_type;
      pau_latch_t latch_select;
      logic blocking;
      logic signed [`PAU_VAL_W-1:0] level;
   } pau_alarm_cfg_t;
   typedef struct packed {
      logic signed [`PAU_VAL_W-1:0] process_value;
      logic signed [`PAU_VAL_W-1:0] setpoint_value;
      logic [`PAU_VAL_W-1:0] load_current;
   } pau_meas_t;
   typedef enum logic [2:0] {
      PAU_ST_IDLE = 3'h1,
      PAU_ST_ACTIVE = 3'h2,
      PAU_ST_CLEARED = 3'h4
   } pau_state_t;
endpackage : pau_pkg

// file: hw/pau_alarm_cell.sv
// one configurable process alarm: compare, block, latch, acknowledge
// sample_en marks a new measurement; ack_pulse is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module pau_alarm_cell
   import pau_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic sample_en,
   input wire logic ack_pulse,
   input wire pau_alarm_cfg_t cfg,
   input wire pau_meas_t meas,
   output logic alarm_active
);
   logic signed [`PAU_VAL_W:0] dev;
   logic signed [`PAU_VAL_W:0] lvl;
   logic signed [`PAU_VAL_W:0] neg_lvl;
   logic signed [`PAU_VAL_W:0] pv;
   logic signed [`PAU_VAL_W:0] cur;
   logic cond;
   logic armed;
   logic next_armed;
   logic ack_mem;
   logic next_ack_mem;
   pau_state_t state;
   pau_state_t next_state;

   always_comb begin
      pv = {meas.process_value[`PAU_VAL_W-1], meas.process_value};
      dev = pv - {meas.setpoint_value[`PAU_VAL_W-1], meas.setpoint_value};
      lvl = {cfg.level[`PAU_VAL_W-1], cfg.level};
      neg_lvl = -lvl;
      cur = {1'b0, meas.load_current};
      case (cfg.alarm_type)
         PAU_FS_HIGH: cond = pv > lvl;
         PAU_FS_LOW: cond = pv < lvl;
         PAU_DEV_BAND: cond = (dev > lvl) || (dev < neg_lvl);
         PAU_DEV_HIGH: cond = dev > lvl;
         PAU_DEV_LOW: cond = dev < lvl;
         PAU_CUR_HIGH: cond = cur > lvl;
         PAU_CUR_LOW: cond = cur < lvl;
         default: cond = 1'b0;
      endcase
   end

   always_comb begin
      next_state = state;
      next_armed = armed;
      next_ack_mem = ack_mem;
      if (sample_en) begin
         // blocking alarm waits for a first quiet sample
         if (!cond) begin
            next_armed = 1'b1;
         end
      end
      case (state)
         PAU_ST_IDLE: begin
            if (sample_en && cond && (armed || !cfg.blocking)) begin
               next_state = PAU_ST_ACTIVE;
               next_ack_mem = 1'b0;
            end
         end
         PAU_ST_ACTIVE: begin
            if (ack_pulse && cfg.latch_select == PAU_LATCH_AUTO) begin
               next_ack_mem = 1'b1;
            end
            if (sample_en && !cond) begin
               if (cfg.latch_select == PAU_LATCH_OFF) begin
                  next_state = PAU_ST_IDLE;
               end else if (cfg.latch_select == PAU_LATCH_AUTO
                            && (ack_mem || ack_pulse)) begin
                  next_state = PAU_ST_IDLE;
               end else begin
                  next_state = PAU_ST_CLEARED;
               end
            end
         end
         PAU_ST_CLEARED: begin
            // ack during the condition was dropped; only a later one frees it
            if (sample_en && cond) begin
               next_state = PAU_ST_ACTIVE;
            end else if (ack_pulse) begin
               next_state = PAU_ST_IDLE;
            end
         end
         default: next_state = PAU_ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state <= PAU_ST_IDLE;
         armed <= 1'b0;
         ack_mem <= 1'b0;
      end else begin
         state <= next_state;
         armed <= next_armed;
         ack_mem <= next_ack_mem;
      end
   end

   assign alarm_active = (state != PAU_ST_IDLE);
endmodule // pau_alarm_cell
`default_nettype wire

// file: hw/pau_sync3.sv
// three-stage synchroniser; change accepted when stages two and three agree
// input comes from outside the clk_sys domain
`timescale 1ns/1ps
`default_nettype none
module pau_sync3 (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic pin_in,
   output logic level_out
);
   logic [2:0] stage;
   logic [2:0] next_stage;
   logic next_level;

   always_comb begin
      next_stage = {stage[1:0], pin_in};
      next_level = (stage[1] == stage[2]) ? stage[2] : level_out;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         stage <= 3'h0;
         level_out <= 1'b0;
      end else begin
         stage <= next_stage;
         level_out <= next_level;
      end
   end
endmodule // pau_sync3
`default_nettype wire

// file: hw/pau_top.sv
// process alarm unit: four alarms, nine output functions, output routing
// assumes measurements and sample_en from the same clock; status pins asynchronous
// What this block does
// - four independent alarms, attachable to any outputs
// - grouped sources OR onto one output
// - full-scale high: value above level
// - full-scale low: value below level
// - deviation band outside symmetric band alarms
// - deviation high: value minus setpoint above
// - deviation low: difference below level
// - high current: load current above level
// - low current: load current below level
// - latch off, auto or manual; holds
// - auto: early acknowledge remembered, clears later
// - manual: acknowledge only after condition clears
// - blocking waits for first inactive condition
// - per-output polarity selects relay energise sense
// - soft alarms drive nothing unless attached
// - nine output functions routable to outputs
// - sensor break on open measurement input
// - loop break when output change unanswered
// - new-alarm pulse when any alarm rises
// - clear held two seconds detaches output
`timescale 1ns/1ps
`default_nettype none
module pau_top
   import pau_pkg::*;
#(
   parameter int unsigned CLEAR_HOLD_CYC = `PAU_CLEAR_HOLD_CYC
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic sample_en,
   input wire pau_meas_t meas,
   input wire pau_alarm_cfg_t alarm_cfg [`PAU_NUM_ALARMS],
   input wire logic ack_pin,
   input wire logic input_open_pin,
   input wire logic manual_mode,
   input wire logic out_of_range,
   input wire logic remote_sp_fail_pin,
   input wire logic load_fail_pin,
   input wire logic heater_fail_pin,
   input wire logic relay_fail_pin,
   input wire logic program_end,
   input wire logic signed [`PAU_VAL_W-1:0] control_output,
   input wire logic [`PAU_VAL_W-1:0] loop_step,
   input wire logic [`PAU_SRC_W-1:0] attach_we [`PAU_NUM_OUTS],
   input wire logic [`PAU_SRC_W-1:0] attach_set [`PAU_NUM_OUTS],
   input wire logic [`PAU_NUM_OUTS-1:0] out_energise_on_alarm,
   input wire logic [`PAU_NUM_OUTS-1:0] clear_show,
   output logic [`PAU_NUM_ALARMS-1:0] alarm_active,
   output logic [`PAU_NUM_FUNCS-1:0] func_active,
   output logic new_alarm,
   output logic [`PAU_SRC_W-1:0] attach_map [`PAU_NUM_OUTS],
   output logic plug_output_one,
   output logic plug_output_two,
   output logic fixed_relay_a,
   output logic fixed_relay_three,
   output logic high_current_relay
);
   logic [`PAU_NUM_ALARMS-1:0] alarm_raw;
   logic [`PAU_NUM_ALARMS-1:0] alarm_prev;
   logic [`PAU_NUM_ALARMS-1:0] next_alarm_prev;
   logic ack_lvl;
   logic ack_d;
   logic ack_pulse;
   logic [5:0] pin_lvl;
   logic [`PAU_NUM_FUNCS-1:0] func_now;
   logic [`PAU_SRC_W-1:0] src_vec;
   logic [`PAU_NUM_OUTS-1:0] relay_drive;
   logic [`PAU_NUM_OUTS-1:0] next_relay_drive;
   logic [`PAU_SRC_W-1:0] next_attach [`PAU_NUM_OUTS];
   logic [31:0] clear_cnt [`PAU_NUM_OUTS];
   logic [31:0] next_clear_cnt [`PAU_NUM_OUTS];
   logic [`PAU_NUM_OUTS-1:0] clear_fire;
   logic next_new_alarm;
   logic signed [`PAU_VAL_W-1:0] loop_ref_out;
   logic signed [`PAU_VAL_W-1:0] next_loop_ref_out;
   logic signed [`PAU_VAL_W-1:0] loop_ref_pv;
   logic signed [`PAU_VAL_W-1:0] next_loop_ref_pv;
   logic [15:0] loop_cnt;
   logic [15:0] next_loop_cnt;
   logic loop_watch;
   logic next_loop_watch;
   logic loop_break;
   logic next_loop_break;
   logic signed [`PAU_VAL_W:0] out_step;
   logic signed [`PAU_VAL_W:0] pv_step;
   logic [`PAU_VAL_W:0] out_mag;
   logic [`PAU_VAL_W:0] pv_mag;

   // all four alarms share one cell design
   genvar gi;
   generate
      for (gi = 0; gi < `PAU_NUM_ALARMS; gi++) begin : g_alarm
         pau_alarm_cell u_cell (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .sample_en(sample_en),
            .ack_pulse(ack_pulse),
            .cfg(alarm_cfg[gi]),
            .meas(meas),
            .alarm_active(alarm_raw[gi])
         );
      end
      for (gi = 0; gi < 6; gi++) begin : g_sync
         pau_sync3 u_sync (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .pin_in((gi == 0) ? input_open_pin :
                    (gi == 1) ? remote_sp_fail_pin :
                    (gi == 2) ? load_fail_pin :
                    (gi == 3) ? heater_fail_pin :
                    (gi == 4) ? relay_fail_pin :
                    ack_pin),
            .level_out(pin_lvl[gi])
         );
      end
   endgenerate

   assign ack_lvl = pin_lvl[5];
   assign ack_pulse = ack_lvl && !ack_d;

   // loop break: a large output step with no process response in time
   always_comb begin
      out_step = {control_output[`PAU_VAL_W-1], control_output}
               - {loop_ref_out[`PAU_VAL_W-1], loop_ref_out};
      pv_step = {meas.process_value[`PAU_VAL_W-1], meas.process_value}
              - {loop_ref_pv[`PAU_VAL_W-1], loop_ref_pv};
      out_mag = out_step[`PAU_VAL_W] ? (`PAU_VAL_W+1)'(-out_step) : out_step;
      pv_mag = pv_step[`PAU_VAL_W] ? (`PAU_VAL_W+1)'(-pv_step) : pv_step;
      next_loop_ref_out = loop_ref_out;
      next_loop_ref_pv = loop_ref_pv;
      next_loop_cnt = loop_cnt;
      next_loop_watch = loop_watch;
      next_loop_break = loop_break;
      if (sample_en) begin
         if (pv_mag > {1'b0, loop_step}) begin
            next_loop_watch = 1'b0;
            next_loop_break = 1'b0;
            next_loop_ref_pv = meas.process_value;
            next_loop_ref_out = control_output;
         end else if (out_mag > {1'b0, loop_step} && !loop_watch) begin
            next_loop_watch = 1'b1;
            next_loop_cnt = 16'h0000;
            next_loop_ref_out = control_output;
         end else if (loop_watch) begin
            if (loop_cnt >= `PAU_LOOP_TIMEOUT_SAMPLES) begin
               next_loop_break = 1'b1;
            end else begin
               next_loop_cnt = loop_cnt + 16'h0001;
            end
         end
      end
   end

   always_comb begin
      func_now = '0;
      func_now[`PAU_FN_SENSOR_BREAK] = pin_lvl[0];
      func_now[`PAU_FN_LOOP_BREAK] = loop_break;
      func_now[`PAU_FN_LOAD_FAIL] = pin_lvl[2];
      func_now[`PAU_FN_MANUAL] = manual_mode;
      func_now[`PAU_FN_OUT_RANGE] = out_of_range;
      func_now[`PAU_FN_REMOTE_SP_FAIL] = pin_lvl[1];
      func_now[`PAU_FN_HEATER_FAIL] = pin_lvl[3];
      func_now[`PAU_FN_RELAY_FAIL] = pin_lvl[4];
      func_now[`PAU_FN_PROGRAM_END] = program_end;
      next_alarm_prev = alarm_raw;
      next_new_alarm = |(alarm_raw & ~alarm_prev);
      src_vec = {next_new_alarm, func_now, alarm_raw};
   end

   // attach map and two-second clear per output
   always_comb begin
      for (int o = 0; o < `PAU_NUM_OUTS; o++) begin
         next_clear_cnt[o] = clear_show[o] ? clear_cnt[o] : 32'h0;
         clear_fire[o] = 1'b0;
         if (clear_show[o]) begin
            if (clear_cnt[o] >= CLEAR_HOLD_CYC - 1) begin
               clear_fire[o] = (clear_cnt[o] == CLEAR_HOLD_CYC - 1);
               next_clear_cnt[o] = CLEAR_HOLD_CYC;
            end else begin
               next_clear_cnt[o] = clear_cnt[o] + 32'h1;
            end
         end
         next_attach[o] = (attach_map[o] & ~attach_we[o]) | (attach_set[o] & attach_we[o]);
         if (clear_fire[o]) begin
            next_attach[o] = '0;
         end
         // unattached soft alarms only indicate
         next_relay_drive[o] = ~(|(src_vec & next_attach[o]));
         if (|(src_vec & next_attach[o])) begin
            next_relay_drive[o] = out_energise_on_alarm[o];
         end else begin
            next_relay_drive[o] = !out_energise_on_alarm[o];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         alarm_prev <= '0;
         alarm_active <= '0;
         func_active <= '0;
         new_alarm <= 1'b0;
         ack_d <= 1'b0;
         relay_drive <= '0;
         loop_ref_out <= '0;
         loop_ref_pv <= '0;
         loop_cnt <= 16'h0000;
         loop_watch <= 1'b0;
         loop_break <= 1'b0;
         for (int o = 0; o < `PAU_NUM_OUTS; o++) begin
            attach_map[o] <= '0;
            clear_cnt[o] <= 32'h0;
         end
      end else begin
         alarm_prev <= next_alarm_prev;
         alarm_active <= alarm_raw;
         func_active <= func_now;
         new_alarm <= next_new_alarm;
         ack_d <= ack_lvl;
         relay_drive <= next_relay_drive;
         loop_ref_out <= next_loop_ref_out;
         loop_ref_pv <= next_loop_ref_pv;
         loop_cnt <= next_loop_cnt;
         loop_watch <= next_loop_watch;
         loop_break <= next_loop_break;
         for (int o = 0; o < `PAU_NUM_OUTS; o++) begin
            attach_map[o] <= next_attach[o];
            clear_cnt[o] <= next_clear_cnt[o];
         end
      end
   end

   assign plug_output_one = relay_drive[0];
   assign plug_output_two = relay_drive[1];
   assign fixed_relay_a = relay_drive[2];
   assign fixed_relay_three = relay_drive[3];
   assign high_current_relay = relay_drive[4];
endmodule // pau_top
`default_nettype wire

// file: tb/pau_top_monitor.sv
// checker on the alarm unit top ports
// bound to pau_top from the bench top file
`timescale 1ns/1ps
`default_nettype none
module pau_top_monitor
   import pau_pkg::*;
#(
   parameter int unsigned CLEAR_HOLD_CYC = 8
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic sample_en,
   input wire pau_meas_t meas,
   input wire pau_alarm_cfg_t alarm_cfg [`PAU_NUM_ALARMS],
   input wire logic input_open_pin,
   input wire logic manual_mode,
   input wire logic [`PAU_SRC_W-1:0] attach_we [`PAU_NUM_OUTS],
   input wire logic [`PAU_NUM_OUTS-1:0] out_energise_on_alarm,
   input wire logic [`PAU_NUM_OUTS-1:0] clear_show,
   input wire logic [`PAU_NUM_ALARMS-1:0] alarm_active,
   input wire logic [`PAU_NUM_FUNCS-1:0] func_active,
   input wire logic new_alarm,
   input wire logic [`PAU_SRC_W-1:0] attach_map [`PAU_NUM_OUTS],
   input wire logic plug_output_one,
   input wire logic plug_output_two
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   int unsigned clear_cnt;
   int unsigned next_clear_cnt;
   logic fsh_hot;
   assign fsh_hot = meas.process_value > alarm_cfg[0].level;
   always_comb begin
      next_clear_cnt = clear_show[0] ? clear_cnt + 1 : 0;
   end
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         clear_cnt <= 0;
      end else begin
         clear_cnt <= next_clear_cnt;
      end
   end
   a_new_alarm_edge: assert property (new_alarm == |(alarm_active & ~$past(alarm_active)))
      else $error("new alarm flag not tied to a rising alarm");
   a_rise_after_sample: assert property (|(alarm_active & ~$past(alarm_active)) |-> $past(sample_en, 2))
      else $error("alarm rose without a sample");
   a_fsh_follows_level: assert property (sample_en && alarm_cfg[0].alarm_type == PAU_FS_HIGH
      && alarm_cfg[0].latch_select == PAU_LATCH_OFF && !alarm_cfg[0].blocking
      |=> ##1 alarm_active[0] == $past(fsh_hot, 2))
      else $error("high alarm does not follow the value");
   // relays hold their reset value for one edge after release
   a_relay_one_sense: assert property ($past(rst_n) && $stable(attach_map[0])
      && $stable(out_energise_on_alarm)
      && attach_map[0][13:4] == 10'h000
      |-> plug_output_one == (|(attach_map[0][3:0] & alarm_active) ~^ out_energise_on_alarm[0]))
      else $error("relay one sense wrong");
   a_relay_two_group: assert property ($past(rst_n) && $stable(attach_map[1])
      && $stable(out_energise_on_alarm)
      && attach_map[1][13:4] == 10'h000
      |-> plug_output_two == (|(attach_map[1][3:0] & alarm_active) ~^ out_energise_on_alarm[1]))
      else $error("relay two group wrong");
   a_clear_detaches_map: assert property (clear_cnt > CLEAR_HOLD_CYC && attach_we[0] == 14'h0000
      |-> attach_map[0] == 14'h0000)
      else $error("held clear left sources attached");
   a_manual_func_rise: assert property ($rose(manual_mode) |-> ##[1:2] func_active[3])
      else $error("manual function late");
   a_sensor_break_rise: assert property ($rose(input_open_pin) |-> ##[2:8] func_active[0])
      else $error("sensor break function late");
endmodule // pau_top_monitor
`default_nettype wire

// file: tb/pau_field.sv
// operator acknowledge button and plant fault contacts
// bench asks by level; contacts move 17 ns after the rising clock edge, a fixed phase
`timescale 1ns/1ps
`default_nettype none
module pau_field #(
   parameter int PRESS_CYC = 12
) (
   input wire logic clk_sys,
   input wire logic press,
   input wire logic [4:0] fault_req,
   output logic ack_pin,
   output logic [4:0] fault_pins
);
   int cnt;
   initial begin
      ack_pin = 1'b0;
      fault_pins = 5'h00;
      cnt = 0;
   end
   // a press is held like a human finger, many clocks long
   always @(posedge clk_sys) begin
      fault_pins <= #17 fault_req;
      if (press && cnt == 0) begin
         cnt <= PRESS_CYC;
      end else if (cnt != 0) begin
         cnt <= cnt - 1;
      end
      ack_pin <= #17 (cnt > 1);
   end
endmodule // pau_field
`default_nettype wire

// file: tb/pau_top_bench.sv
// self-checking bench for the process alarm unit top
// field model gives acknowledge and faults; monitor bound at the foot
`timescale 1ns/1ps
`default_nettype none
module pau_top_bench
   import pau_pkg::*;
;
   logic clk_sys, rst_n, sample_en, press, manual_mode, out_of_range, program_end, ack_pin;
   logic new_alarm, att0;
   logic [4:0] fault_req, fault_pins, energise, clear_show, relays;
   pau_meas_t meas;
   pau_alarm_cfg_t alarm_cfg [`PAU_NUM_ALARMS];
   logic signed [15:0] control_output;
   logic [15:0] loop_step;
   logic [13:0] attach_we [5], attach_set [5], attach_map [5];
   logic [3:0] alarm_active;
   logic [8:0] func_active;
   int failures, checks_done;
   int cpv [7] = '{100, 100, 0, 200, 200, 0, 0};
   int csp [7] = '{0, 0, 100, 100, 100, 0, 0};
   int dpv [7] = '{1, -1, -1, 1, -1, 0, 0};
   int fi [8] = '{0, 5, 2, 6, 7, 3, 4, 8};
   pau_field i_field (.clk_sys, .press, .fault_req, .ack_pin, .fault_pins);
   pau_top #(.CLEAR_HOLD_CYC(8)) i_dut (.clk_sys, .rst_n, .sample_en, .meas, .alarm_cfg,
      .ack_pin, .input_open_pin(fault_pins[0]), .manual_mode, .out_of_range,
      .remote_sp_fail_pin(fault_pins[1]), .load_fail_pin(fault_pins[2]),
      .heater_fail_pin(fault_pins[3]), .relay_fail_pin(fault_pins[4]), .program_end,
      .control_output, .loop_step, .attach_we, .attach_set,
      .out_energise_on_alarm(energise), .clear_show, .alarm_active, .func_active,
      .new_alarm, .attach_map, .plug_output_one(relays[0]), .plug_output_two(relays[1]),
      .fixed_relay_a(relays[2]), .fixed_relay_three(relays[3]),
      .high_current_relay(relays[4]));
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic edges(input int n);
      repeat (n) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask
   // alarms 1 and 2 stay high-value types at 200 and 100; 1 is grouped, 2 soft
   task automatic apply(input int pv, sp, cur, input logic e0);
      logic a1;
      logic a2;
      a1 = pv > 200;
      a2 = pv > 100;
      @(posedge clk_sys);
      meas <= '{16'(pv), 16'(sp), 16'(cur)};
      sample_en <= 1'b1;
      @(posedge clk_sys);
      sample_en <= 1'b0;
      edges(1);
      chk("alarms", alarm_active, {1'b0, a2, a1, e0});
      chk("relays", relays, {2'b11, 1'b0, ~(e0 | a1), att0 & e0});
   endtask
   task automatic set_cfg(input pau_latch_t l, input logic b, input int t);
      @(posedge clk_sys);
      alarm_cfg[0] <= '{pau_type_t'(t), l, b, 16'sh0064};
   endtask
   task automatic wire_up;
      for (int o = 0; o < 4; o += 1 + o) begin
         @(posedge clk_sys);
         attach_we[o] <= 14'h3FFF;
         attach_set[o] <= (o == 3) ? 14'h1000 : 14'(o + 1 + o);
         @(posedge clk_sys);
         attach_we[o] <= 14'h0000;
      end
   endtask
   task automatic ack;
      @(posedge clk_sys);
      press <= 1'b1;
      @(posedge clk_sys);
      press <= 1'b0;
      edges(20);
   endtask
   task automatic do_reset;
      @(posedge clk_sys);
      rst_n <= 1'b0;
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      edges(2);
   endtask
   task automatic drive_fn(input int i, input logic v);
      @(posedge clk_sys);
      if (i < 5) fault_req[i] <= v;
      else if (i == 5) manual_mode <= v;
      else if (i == 6) out_of_range <= v;
      else program_end <= v;
      edges(12);
   endtask
   initial forever #25 clk_sys = ~clk_sys;
   initial begin
      repeat (20000) @(posedge clk_sys);
      failures++;
      complete_run;
   end
   initial begin
      {clk_sys, rst_n, sample_en, press, manual_mode, out_of_range, program_end} = 7'h00;
      {fault_req, clear_show, energise} = 15'h0005;
      meas = '0;
      control_output = 16'sh0000;
      loop_step = 16'h000A;
      att0 = 1'b1;
      failures = 0;
      checks_done = 0;
      for (int a = 0; a < 4; a++) alarm_cfg[a] = '{PAU_FS_HIGH, PAU_LATCH_OFF, 1'b0, 16'sh0064};
      alarm_cfg[1].level = 16'sh00C8;
      alarm_cfg[3].level = 16'sh7530;
      for (int o = 0; o < 5; o++) {attach_we[o], attach_set[o]} = 28'h0000000;
      do_reset;
      chk("idle relays", relays, 5'h1A);
      wire_up;
      edges(1);
      chk("group map", attach_map[1], 14'h0003);
      for (int t = 0; t < 7; t++) begin
         set_cfg(PAU_LATCH_OFF, 1'b0, t);
         apply(cpv[t] + dpv[t], csp[t], (t == 5) ? 101 : (t == 6) ? 99 : 0, 1'b1);
         apply(cpv[t], csp[t], (t > 4) ? 100 : 0, 1'b0);
      end
      set_cfg(PAU_LATCH_MANUAL, 1'b0, 0);
      apply(101, 0, 0, 1'b1);
      ack;
      chk("manual early ack", alarm_active[0], 1'b1);
      apply(100, 0, 0, 1'b1);
      ack;
      chk("manual late ack", alarm_active[0], 1'b0);
      set_cfg(PAU_LATCH_AUTO, 1'b0, 0);
      apply(101, 0, 0, 1'b1);
      ack;
      apply(100, 0, 0, 1'b0);
      set_cfg(PAU_LATCH_OFF, 1'b1, 0);
      do_reset;
      wire_up;
      apply(101, 0, 0, 1'b0);
      apply(100, 0, 0, 1'b0);
      apply(101, 0, 0, 1'b1);
      set_cfg(PAU_LATCH_OFF, 1'b0, 0);
      for (int i = 0; i < 8; i++) begin
         drive_fn(i, 1'b1);
         chk("function on", func_active, 9'h001 << fi[i]);
         chk("end relay", relays[3], fi[i] != 8);
         drive_fn(i, 1'b0);
         chk("function off", func_active, 9'h000);
      end
      // settle the process reference first so only the output step is seen
      apply(0, 0, 0, 1'b0);
      @(posedge clk_sys);
      control_output <= 16'sh03E8;
      repeat (70) apply(0, 0, 0, 1'b0);
      chk("loop break", func_active, 9'h002);
      repeat (2) apply(20, 0, 0, 1'b0);
      chk("loop answered", func_active, 9'h000);
      @(posedge clk_sys);
      clear_show <= 5'h01;
      edges(12);
      @(posedge clk_sys);
      clear_show <= 5'h00;
      chk("cleared map", attach_map[0], 14'h0000);
      chk("kept map", attach_map[1], 14'h0003);
      att0 = 1'b0;
      apply(101, 0, 0, 1'b1);
      complete_run;
   end
endmodule // pau_top_bench
bind pau_top pau_top_monitor #(.CLEAR_HOLD_CYC(CLEAR_HOLD_CYC)) i_mon (.clk_sys, .rst_n,
   .sample_en, .meas, .alarm_cfg, .input_open_pin, .manual_mode, .attach_we,
   .out_energise_on_alarm, .clear_show, .alarm_active, .func_active, .new_alarm,
   .attach_map, .plug_output_one, .plug_output_two);
`default_nettype wire
